// ### src/psc_pkg.sv
// shared constants, states and carriers of the proximity control block
package psc_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 10;
	localparam int STEP_NS = 2_720_000;
	localparam int STEP_CYC = STEP_NS / CLK_NS;
	localparam int PULSE_PERIOD_NS = 16_000;
	localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_NS;
	localparam int LED_ON_NS = 7_200;
	localparam int LED_ON_CYC = LED_ON_NS / CLK_NS;
	// byte offsets
	localparam logic [5:0] OFS_ENABLE = 6'h00;
	localparam logic [5:0] OFS_CONFIG = 6'h04;
	localparam logic [5:0] OFS_TIMING = 6'h08;
	localparam logic [5:0] OFS_THRESH = 6'h0c;
	localparam logic [5:0] OFS_PERSIST = 6'h10;
	localparam logic [5:0] OFS_DATA = 6'h14;
	localparam logic [5:0] OFS_PROX = 6'h18;
	localparam logic [5:0] OFS_STATUS = 6'h1c;
	localparam logic [5:0] OFS_MASK = 6'h20;
	localparam logic [5:0] OFS_STATE = 6'h24;
	// enable bits
	localparam int EN_POWER = 0;
	localparam int EN_PROX = 1;
	localparam int EN_WAIT = 2;
	localparam int EN_INT = 3;
	// config fields
	localparam int CFG_DRIVE_LSB = 8;
	localparam int CFG_CHAN_LSB = 12;
	// timing fields
	localparam int TIM_WAIT_LSB = 8;
	// status bits
	localparam int ST_PROX = 0;
	localparam int ST_DONE = 1;
	localparam int ST_W = 2;
	// reset values
	localparam logic [7:0] PULSES_RST = 8'h08;
	localparam logic [15:0] THR_HI_RST = 16'hffff;
	localparam logic [3:0] PERSIST_RST = 4'h1;
	// channel select
	localparam logic [1:0] CH_VIS = 2'h1;
	localparam logic [1:0] CH_IR = 2'h2;
	localparam logic [1:0] CH_BOTH = 2'h3;
	typedef enum logic [2:0] {
		SLEEP = 3'h0, PULSE = 3'h1, INTEG = 3'h3, XFER = 3'h2, EVAL = 3'h6, WAIT = 3'h7
	} psc_state_e;
	typedef struct packed {
		logic [1:0] chan;
		logic [1:0] drive;
		logic [7:0] pulses;
	} psc_cfg_s;
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} psc_thr_s;
endpackage : psc_pkg

// ### src/psc_top.sv
// proximity sense control: led burst, integration, thresholds, interrupt
`timescale 1ns/1ps
// How it works
// - led drive strength selects one of four currents
// - burst holds programmed 1 to 255 pulses
// - pulses back to back, 16 us period each
// - both 16-bit channel results captured together
// - proximity uses either channel or both
// - completed conversion copied into data registers
// - interrupt is a level on own pin
// - interrupt only when enabled and a masked-in status bit is set: exceeded, or conversion done
// - exceed means above upper or below lower
// - persistence count of consecutive exceeds triggers
// - interrupt held until host clears status, masks it or disables it
// - host bus configures device, reads results
// - wait timer idles 2.72 ms to 696.32 ms
// - state machine walks sleep, prox, wait, then back to prox
// - wait interval is 1 to 256 steps
// - integration time is 1 to 256 steps
module psc_top #(
	parameter int STEP_CYC = psc_pkg::STEP_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// analogue front end
	input wire logic [15:0] visible_ir_channel,
	input wire logic [15:0] ir_only_channel,
	output logic adc_integrate,
	output logic [1:0] led_drive,
	// open-drain pins
	output logic led_sink_out,
	output logic led_sink_oe,
	output logic int_out,
	output logic int_oe
);
	psc_pkg::psc_state_e state;
	psc_pkg::psc_cfg_s cfg;
	psc_pkg::psc_thr_s thr;
	logic [3:0] enable;
	logic [7:0] integ_set;
	logic [7:0] wait_set;
	logic [3:0] persist;
	logic [15:0] data_vis;
	logic [15:0] data_ir;
	logic [15:0] prox;
	logic [psc_pkg::ST_W-1:0] status;
	logic [psc_pkg::ST_W-1:0] mask;
	logic [15:0] vis_s1;
	logic [15:0] vis_s2;
	logic [15:0] ir_s1;
	logic [15:0] ir_s2;
	logic [18:0] tick;
	logic [10:0] pcyc;
	logic [7:0] pnum;
	logic [8:0] steps;
	logic [3:0] exceed_cnt;
	logic wr_ok;
	logic step_end;
	logic period_end;
	logic running;
	logic exceed;
	logic hit;
	logic [16:0] sum;
	logic [7:0] last_pulse;
	logic [3:0] need;
	logic [31:0] rd_mux;

	assign wr_ok = write && !waitrequest;
	assign running = enable[psc_pkg::EN_POWER] && enable[psc_pkg::EN_PROX];
	assign step_end = tick == 19'(STEP_CYC - 1);
	assign period_end = pcyc == 11'(psc_pkg::PULSE_PERIOD_CYC - 1);
	// a count of zero still fires one pulse
	assign last_pulse = (cfg.pulses == 8'h00) ? 8'h00 : cfg.pulses - 8'h01;
	assign need = (persist == 4'h0) ? 4'h1 : persist;
	assign sum = {1'b0, data_vis} + {1'b0, data_ir};
	assign exceed = prox > thr.high || prox < thr.low;
	// one spare bit so a saturated count still sees the threshold
	assign hit = exceed && ({1'b0, exceed_cnt} + 5'h01 >= {1'b0, need});

	always_comb begin
		case (cfg.chan)
			psc_pkg::CH_VIS: prox = data_vis;
			psc_pkg::CH_IR: prox = data_ir;
			default: prox = sum[16] ? 16'hffff : sum[15:0];
		endcase
	end

	// front end words cross in from the analogue clocking
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			vis_s1 <= 16'h0000;
			vis_s2 <= 16'h0000;
			ir_s1 <= 16'h0000;
			ir_s2 <= 16'h0000;
		end else begin
			vis_s1 <= visible_ir_channel;
			vis_s2 <= vis_s1;
			ir_s1 <= ir_only_channel;
			ir_s2 <= ir_s1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= psc_pkg::SLEEP;
			tick <= 19'h0_0000;
			pcyc <= 11'h000;
			pnum <= 8'h00;
			steps <= 9'h000;
		end else if (!running) begin
			state <= psc_pkg::SLEEP;
			tick <= 19'h0_0000;
			pcyc <= 11'h000;
			pnum <= 8'h00;
			steps <= 9'h000;
		end else begin
			case (state)
				psc_pkg::SLEEP: begin
					state <= psc_pkg::PULSE;
				end
				psc_pkg::PULSE: begin
					pcyc <= period_end ? 11'h000 : pcyc + 11'h001;
					if (period_end) begin
						pnum <= pnum + 8'h01;
						if (pnum == last_pulse) begin
							pnum <= 8'h00;
							state <= psc_pkg::INTEG;
						end
					end
				end
				psc_pkg::INTEG: begin
					tick <= step_end ? 19'h0_0000 : tick + 19'h0_0001;
					if (step_end) begin
						steps <= steps + 9'h001;
						if (steps == {1'b0, integ_set}) begin
							steps <= 9'h000;
							state <= psc_pkg::XFER;
						end
					end
				end
				psc_pkg::XFER: begin
					state <= psc_pkg::EVAL;
				end
				psc_pkg::EVAL: begin
					state <= enable[psc_pkg::EN_WAIT] ? psc_pkg::WAIT : psc_pkg::PULSE;
				end
				psc_pkg::WAIT: begin
					tick <= step_end ? 19'h0_0000 : tick + 19'h0_0001;
					if (step_end) begin
						steps <= steps + 9'h001;
						if (steps == {1'b0, wait_set}) begin
							steps <= 9'h000;
							state <= psc_pkg::PULSE;
						end
					end
				end
				default: begin
					state <= psc_pkg::SLEEP;
				end
			endcase
		end
	end

	// led and front end drive
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			led_sink_out <= 1'b0;
			led_sink_oe <= 1'b0;
			led_drive <= 2'h0;
			adc_integrate <= 1'b0;
		end else begin
			led_sink_out <= 1'b0;
			led_sink_oe <= state == psc_pkg::PULSE && pcyc < 11'(psc_pkg::LED_ON_CYC);
			led_drive <= cfg.drive;
			adc_integrate <= state == psc_pkg::INTEG;
		end
	end

	// results land only when a full cycle finishes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_vis <= 16'h0000;
			data_ir <= 16'h0000;
		end else if (state == psc_pkg::XFER) begin
			data_vis <= vis_s2;
			data_ir <= ir_s2;
		end
	end

	// persistence filter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			exceed_cnt <= 4'h0;
		end else if (state == psc_pkg::EVAL) begin
			if (!exceed) begin
				exceed_cnt <= 4'h0;
			end else if (exceed_cnt != 4'hf) begin
				exceed_cnt <= exceed_cnt + 4'h1;
			end
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			status <= '0;
		end else begin
			if (wr_ok && address == psc_pkg::OFS_STATUS) begin
				status <= status & ~writedata[psc_pkg::ST_W-1:0];
			end
			if (state == psc_pkg::EVAL && hit) begin
				status[psc_pkg::ST_PROX] <= 1'b1;
			end
			if (state == psc_pkg::XFER) begin
				status[psc_pkg::ST_DONE] <= 1'b1;
			end
		end
	end

	// level output, open drain pulled low while asserted
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			int_out <= 1'b0;
			int_oe <= 1'b0;
		end else begin
			int_out <= 1'b0;
			int_oe <= enable[psc_pkg::EN_INT] && |(status & mask);
		end
	end

	// configuration writes; the bus stands in for the two-wire port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			enable <= 4'h0;
			cfg <= '{chan: psc_pkg::CH_BOTH, drive: 2'h0, pulses: psc_pkg::PULSES_RST};
			integ_set <= 8'h00;
			wait_set <= 8'h00;
			thr <= '{high: psc_pkg::THR_HI_RST, low: 16'h0000};
			persist <= psc_pkg::PERSIST_RST;
			mask <= '0;
		end else if (wr_ok) begin
			case (address)
				psc_pkg::OFS_ENABLE: enable <= writedata[3:0];
				psc_pkg::OFS_CONFIG: begin
					cfg.pulses <= writedata[7:0];
					cfg.drive <= writedata[psc_pkg::CFG_DRIVE_LSB +: 2];
					cfg.chan <= writedata[psc_pkg::CFG_CHAN_LSB +: 2];
				end
				psc_pkg::OFS_TIMING: begin
					integ_set <= writedata[7:0];
					wait_set <= writedata[psc_pkg::TIM_WAIT_LSB +: 8];
				end
				psc_pkg::OFS_THRESH: thr <= writedata;
				psc_pkg::OFS_PERSIST: persist <= writedata[3:0];
				psc_pkg::OFS_MASK: mask <= writedata[psc_pkg::ST_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (address)
			psc_pkg::OFS_ENABLE: rd_mux = {28'h000_0000, enable};
			psc_pkg::OFS_CONFIG: rd_mux = {18'h0_0000, cfg.chan, 2'h0, cfg.drive, cfg.pulses};
			psc_pkg::OFS_TIMING: rd_mux = {16'h0000, wait_set, integ_set};
			psc_pkg::OFS_THRESH: rd_mux = thr;
			psc_pkg::OFS_PERSIST: rd_mux = {28'h000_0000, persist};
			psc_pkg::OFS_DATA: rd_mux = {data_ir, data_vis};
			psc_pkg::OFS_PROX: rd_mux = {16'h0000, prox};
			psc_pkg::OFS_STATUS: rd_mux = {30'h0000_0000, status};
			psc_pkg::OFS_MASK: rd_mux = {30'h0000_0000, mask};
			psc_pkg::OFS_STATE: rd_mux = {25'h000_0000, exceed_cnt, state};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait cycle per access keeps read data registered
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else begin
			waitrequest <= !(waitrequest && (read || write));
			if (waitrequest && read) begin
				readdata <= rd_mux;
			end
		end
	end
endmodule : psc_top

// ### verif/psc_monitor.sv
// concurrent checks of bus, pin and timing relations at the top ports
`timescale 1ns/1ps
module psc_monitor #(
	parameter int STEP_CYC = 20
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// bus
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// pins
	input wire logic adc_integrate,
	input wire logic led_sink_out,
	input wire logic led_sink_oe,
	input wire logic int_out,
	input wire logic int_oe
);
	int on_c;
	int in_c;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// run lengths of the led on-time and of integration
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			on_c <= 0;
			in_c <= 0;
		end else begin
			on_c <= led_sink_oe ? on_c + 1 : 0;
			in_c <= adc_integrate ? in_c + 1 : 0;
		end
	end
	property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_rest; !waitrequest |=> waitrequest; endproperty
	a_rest: assert property (p_rest) else $error("answer held too long");
	property p_rd; !$stable(readdata) |-> $past(read) && $past(waitrequest); endproperty
	a_rd: assert property (p_rd) else $error("read data moved without a read");
	property p_od; !int_out && !led_sink_out; endproperty
	a_od: assert property (p_od) else $error("open drain pin driven high");
	property p_hold; $fell(int_oe) |-> $past(write, 2) && !$past(waitrequest, 2); endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped on its own");
	property p_on; $fell(led_sink_oe) |-> on_c == psc_pkg::LED_ON_CYC; endproperty
	a_on: assert property (p_on) else $error("led on-time wrong");
	property p_integ; $fell(adc_integrate) |-> in_c > 0 && in_c % STEP_CYC == 0; endproperty
	a_integ: assert property (p_integ) else $error("integration not whole steps");
	property p_rise; $rose(int_oe) |-> !adc_integrate || $past(write, 2); endproperty
	a_rise: assert property (p_rise) else $error("interrupt raised mid conversion");
	c_int: cover property ($rose(int_oe));
	c_clr: cover property ($fell(int_oe));
	c_conv: cover property ($fell(adc_integrate));
endmodule : psc_monitor
bind psc_top psc_monitor #(.STEP_CYC(STEP_CYC)) mon (.sys_clk, .resetn, .read, .write,
	.readdata, .waitrequest, .adc_integrate, .led_sink_out, .led_sink_oe, .int_out, .int_oe);

// ### verif/psc_front_model.sv
// front end stand-in: both channel codes, refreshed as integration starts
`timescale 1ns/1ps
module psc_front_model (
	// from the block
	input wire logic adc_integrate,
	// levels set by the bench
	input wire logic [15:0] vis_lvl,
	input wire logic [15:0] ir_lvl,
	// results
	output logic [15:0] visible_ir_channel = 16'h0000,
	output logic [15:0] ir_only_channel = 16'h0000
);
	// codes move only at integration start, never while the block samples them
	always @(posedge adc_integrate) begin
		visible_ir_channel <= vis_lvl;
		ir_only_channel <= ir_lvl;
	end
endmodule : psc_front_model

// ### verif/test_proximity_sense_control.sv
// self-checking bench of the proximity control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_proximity_sense_control;
	logic sys_clk = 0, resetn = 0, read = 0, write = 0, wr_seen;
	logic [5:0] address = 0;
	logic [31:0] writedata = 0, readdata, rd_seen, rdat;
	logic waitrequest, adc_integrate, led_sink_out, led_sink_oe, int_out, int_oe;
	logic [15:0] vis_ch, ir_ch, vis_lvl = 16'h0200, ir_lvl = 16'h0030;
	logic [1:0] led_drive;
	int mismatches = 0, cmp_count = 0, npulse = 0;
	localparam int SIM_STEP = 20;
	psc_top #(.STEP_CYC(SIM_STEP)) uut (.sys_clk, .resetn, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .visible_ir_channel(vis_ch), .ir_only_channel(ir_ch),
		.adc_integrate, .led_drive, .led_sink_out, .led_sink_oe, .int_out, .int_oe);
	psc_front_model fe (.adc_integrate, .vis_lvl, .ir_lvl, .visible_ir_channel(vis_ch),
		.ir_only_channel(ir_ch));
	always #5 sys_clk = ~sys_clk;
	// values seen just before each rising edge, free of update races
	always @(negedge sys_clk) begin
		wr_seen = waitrequest;
		rd_seen = readdata;
	end
	always @(posedge led_sink_oe) npulse++;
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		do @(posedge sys_clk); while (wr_seen);
		rdat = rd_seen;
		read <= 0;
		write <= 0;
		@(posedge sys_clk);
	endtask : acc
	task automatic conv;
		@(negedge adc_integrate);
		repeat (4) @(posedge sys_clk);
	endtask : conv
	task automatic t_regs;
		acc(0, psc_pkg::OFS_CONFIG, 0);
		`CHK("config", {18'h0_0000, psc_pkg::CH_BOTH, 4'h0, psc_pkg::PULSES_RST}, rdat)
		acc(1, psc_pkg::OFS_DATA, 32'h1234_5678);
		acc(0, psc_pkg::OFS_DATA, 0);
		`CHK("data ro", 32'h0000_0000, rdat)
		acc(0, 6'h3c, 0);
		`CHK("unmapped", 32'h0000_0000, rdat)
		for (int i = 0; i < 4; i++) begin
			acc(1, psc_pkg::OFS_CONFIG, 32'h0000_0002 | (i << 8));
			// drive code is registered once more after the write lands
			@(posedge sys_clk);
			`CHK("drive", 2'(i), led_drive)
		end
	endtask : t_regs
	task automatic t_prox;
		acc(1, psc_pkg::OFS_CONFIG, 32'h0000_1102);
		acc(1, psc_pkg::OFS_TIMING, 32'h0000_0001);
		acc(1, psc_pkg::OFS_THRESH, 32'h0100_0010);
		acc(1, psc_pkg::OFS_PERSIST, 32'h0000_0002);
		acc(1, psc_pkg::OFS_MASK, 32'h0000_0001);
		npulse = 0;
		acc(1, psc_pkg::OFS_ENABLE, 32'h0000_000f);
		conv();
		`CHK("pulses", 2, npulse)
		`CHK("int early", 1'b0, int_oe)
		acc(0, psc_pkg::OFS_DATA, 0);
		`CHK("data", 32'h0030_0200, rdat)
		acc(0, psc_pkg::OFS_PROX, 0);
		`CHK("prox vis", 32'h0000_0200, rdat)
		conv();
		`CHK("int", 1'b1, int_oe)
		acc(1, psc_pkg::OFS_MASK, 0);
		@(posedge sys_clk);
		`CHK("masked", 1'b0, int_oe)
		acc(1, psc_pkg::OFS_MASK, 32'h0000_0001);
		@(posedge sys_clk);
		`CHK("unmasked", 1'b1, int_oe)
	endtask : t_prox
	task automatic t_persist;
		vis_lvl = 16'h0050;
		conv();
		`CHK("held", 1'b1, int_oe)
		acc(0, psc_pkg::OFS_STATE, 0);
		`CHK("count", 4'h0, rdat[6:3])
		acc(1, psc_pkg::OFS_STATUS, 32'h0000_0003);
		@(posedge sys_clk);
		`CHK("cleared", 1'b0, int_oe)
		ir_lvl = 16'h0008;
		acc(1, psc_pkg::OFS_CONFIG, 32'h0000_2002);
		conv();
		acc(0, psc_pkg::OFS_PROX, 0);
		`CHK("prox ir", 32'h0000_0008, rdat)
		vis_lvl = 16'h0005;
		ir_lvl = 16'h0003;
		acc(1, psc_pkg::OFS_CONFIG, 32'h0000_3002);
		conv();
		`CHK("int low", 1'b1, int_oe)
		acc(1, psc_pkg::OFS_ENABLE, 0);
		acc(0, psc_pkg::OFS_STATE, 0);
		`CHK("sleep", psc_pkg::SLEEP, rdat[2:0])
	endtask : t_persist
	task automatic t_wait;
		time t0;
		acc(1, psc_pkg::OFS_CONFIG, 32'h0000_3000);
		acc(1, psc_pkg::OFS_TIMING, 32'h0000_0101);
		npulse = 0;
		acc(1, psc_pkg::OFS_ENABLE, 32'h0000_0007);
		@(negedge adc_integrate);
		t0 = $time;
		`CHK("one pulse", 1, npulse)
		repeat (2) @(posedge sys_clk);
		acc(0, psc_pkg::OFS_STATE, 0);
		`CHK("waiting", psc_pkg::WAIT, rdat[2:0])
		// two wait steps plus the hand-off through eval and the led register
		@(posedge led_sink_oe);
		`CHK("wait time", (2 * SIM_STEP + 2) * psc_pkg::CLK_NS, $time - t0)
		acc(0, psc_pkg::OFS_STATUS, 0);
		`CHK("status", 32'h0000_0003, rdat)
	endtask : t_wait
	task automatic finish_test;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		t_regs();
		t_prox();
		t_persist();
		t_wait();
		finish_test();
	end
	// whole run is near 20000 cycles; this cuts a hang
	initial begin
		#1_000_000;
		mismatches++;
		finish_test();
	end
endmodule : test_proximity_sense_control
